// ===== design/servo_io_pkg.sv
// Package: register map, setting fields, timing constants and carrier types for the servo pulse block
package servo_io_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] CMD_FORM_OFS    = 8'h00;
  localparam logic [7:0] INPOS_RANGE_OFS = 8'h04;
  localparam logic [7:0] PPR_OFS         = 8'h08;
  localparam logic [7:0] PHASE_SEL_OFS   = 8'h0C;
  localparam logic [7:0] DEVIATION_OFS   = 8'h10;
  localparam logic [7:0] STATUS_OFS      = 8'h14;

  // ==========================================================================
  // Command pulse form setting: hex digits, form in digit 0, logic in digit 1, filter in digit 2
  localparam int FORM_LSB   = 0;
  localparam int LOGIC_BIT  = 4;
  localparam int FILTER_LSB = 8;
  localparam logic [11:0] CMD_FORM_RST   = 12'h010;   // Negative logic, separate trains
  localparam logic [1:0]  FORM_FWD_REV   = 2'h0;
  localparam logic [1:0]  FORM_PULSE_DIR = 2'h1;
  localparam logic [1:0]  FORM_QUAD      = 2'h2;
  localparam logic [1:0]  FILT_NONE      = 2'h0;
  localparam logic [1:0]  FILT_500K      = 2'h1;
  localparam logic [1:0]  FILT_200K      = 2'h2;

  // Other reset values
  localparam logic [31:0] INPOS_RANGE_RST = 32'h0000_0064;
  localparam logic [15:0] PPR_RST         = 16'h0FA0;
  localparam logic        PHASE_SEL_RST   = 1'b0;

  // Status bit positions
  localparam int STAT_INPOS_BIT = 0;
  localparam int STAT_ZERO_BIT  = 1;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int ZERO_PULSE_US  = 400;
  localparam int ZERO_PULSE_CYC = (ZERO_PULSE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_500K_NS   = 200;
  localparam int FILT_200K_NS   = 500;
  localparam int FILT_500K_CYC  = (FILT_500K_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_200K_CYC  = (FILT_200K_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FILT_W         = 8;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [11:0] cmd_form;
    logic [31:0] inpos_range;
    logic [15:0] ppr;
    logic        phase_inv;
  } cfg_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } ahb_req_t;

endpackage : servo_io_pkg

// ===== design/servo_pulse_io.sv
// Servo position-mode pulse interface: command decode, droop counter, encoder outputs, AHB-Lite registers
//
// Decided for this implementation: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - One active-low zero-point pulse each revolution, when zero position is reached.
// - Each zero-point pulse lasts at least 400 microseconds.
// - Quadrature A/B outputs, pulses per revolution taken from the setting.
// - Default phase: counter-clockwise rotation makes B lag A by 90 degrees.
// - Phase select setting inverts which direction gives which A/B order.
// - Differential Z carries the same zero-point signal as the open-collector output.
// - Three command pulse forms, each positive or negative logic, chosen by setting.
// - Setting value x10 means negative logic, separate forward and reverse trains.
// - Same setting selects input filter: 1 for 500 kpps, 2 for 200 kpps.
// - In-position flag set while droop count lies within configured range.
// - Flag follows droop only, so may assert during slow motion.
module servo_pulse_io
  import servo_io_pkg::*;
#(
  parameter int CNT_PER_REV     = 131072,
  parameter int ZERO_PULSE_CLKS = ZERO_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Command pulse inputs
  input  wire logic        fwd_cmd_pulse_in,
  input  wire logic        rev_cmd_pulse_in,
  // Motor feedback, one step per encoder count
  input  wire logic        fb_step,
  input  wire logic        fb_ccw,
  // Encoder outputs
  output logic             enc_a_out_p,
  output logic             enc_a_out_n,
  output logic             enc_b_out_p,
  output logic             enc_b_out_n,
  output logic             enc_z_out_p,
  output logic             enc_z_out_n,
  output logic             zero_point_oc_out_n,
  // Status
  output logic             in_position
);

  // ==========================================================================
  // Elaboration checks
  localparam int REV_W = $clog2(CNT_PER_REV);
  localparam int ZW    = $clog2(ZERO_PULSE_CLKS + 1);
  if (CNT_PER_REV < 4 || ZERO_PULSE_CLKS < 1) begin : g_bad_param
    $error("CNT_PER_REV must be at least 4 and ZERO_PULSE_CLKS at least 1");
  end

  // ==========================================================================
  // Register file and AHB-Lite slave
  cfg_t        cfg_r;
  ahb_req_t    req_r;
  logic [31:0] hrdata_r;
  logic signed [31:0] droop_r;
  logic        inpos_r;
  logic        z_active_r;
  logic        dev_clear;

  assign hreadyout = 1'b1;   // Zero wait states
  assign hresp     = 1'b0;   // Always OKAY
  assign hrdata    = hrdata_r;
  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_r <= '0;
    end else begin
      req_r.valid <= hsel & htrans[1] & hready;
      req_r.addr  <= haddr[7:0];
      req_r.write <= hwrite;
    end
  end

  // Register writes in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r.cmd_form    <= CMD_FORM_RST;
      cfg_r.inpos_range <= INPOS_RANGE_RST;
      cfg_r.ppr         <= PPR_RST;
      cfg_r.phase_inv   <= PHASE_SEL_RST;
    end else if (req_r.valid && req_r.write) begin
      unique case (req_r.addr)
        CMD_FORM_OFS:    cfg_r.cmd_form    <= hwdata[11:0];
        INPOS_RANGE_OFS: cfg_r.inpos_range <= hwdata;
        PPR_OFS:         cfg_r.ppr         <= hwdata[15:0];
        PHASE_SEL_OFS:   cfg_r.phase_inv   <= hwdata[0];
        default: ;
      endcase
    end
  end

  // Writing the deviation register clears the droop
  assign dev_clear = req_r.valid & req_r.write & (req_r.addr == DEVIATION_OFS);
  // Read data registered at address phase so it stands through the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= '0;
    end else if (hsel && htrans[1] && hready && !hwrite) begin
      unique case (haddr[7:0])
        CMD_FORM_OFS:    hrdata_r <= {20'h0_0000, cfg_r.cmd_form};
        INPOS_RANGE_OFS: hrdata_r <= cfg_r.inpos_range;
        PPR_OFS:         hrdata_r <= {16'h0000, cfg_r.ppr};
        PHASE_SEL_OFS:   hrdata_r <= {31'h0000_0000, cfg_r.phase_inv};
        DEVIATION_OFS:   hrdata_r <= droop_r;
        STATUS_OFS:      hrdata_r <= {30'h0000_0000, z_active_r, inpos_r};
        default:         hrdata_r <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Command input polarity and noise filter
  logic [1:0]        form;
  logic [1:0]        filt_sel;
  logic [FILT_W-1:0] filt_len;
  logic [1:0]        raw;
  logic [1:0]        filt_r;
  logic [1:0]        prev_r;
  logic [FILT_W-1:0] fcnt_r [2];

  assign form     = cfg_r.cmd_form[FORM_LSB +: 2];
  assign filt_sel = cfg_r.cmd_form[FILTER_LSB +: 2];
  // Negative logic: pin low means active
  assign raw = {rev_cmd_pulse_in, fwd_cmd_pulse_in} ^ {2{cfg_r.cmd_form[LOGIC_BIT]}};

  // Filter length; a longer filter trades top pulse rate for noise immunity
  always_comb begin
    unique case (filt_sel)
      FILT_500K: filt_len = FILT_W'(FILT_500K_CYC);
      FILT_200K: filt_len = FILT_W'(FILT_200K_CYC);
      default:   filt_len = '0;
    endcase
  end

  // Input must hold a new level for filt_len + 1 cycles before it is accepted
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_r    <= '0;
      fcnt_r[0] <= '0;
      fcnt_r[1] <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (raw[i] == filt_r[i]) begin
          fcnt_r[i] <= '0;
        end else if (fcnt_r[i] >= filt_len) begin
          filt_r[i] <= raw[i];
          fcnt_r[i] <= '0;
        end else begin
          fcnt_r[i] <= fcnt_r[i] + 1'b1;
        end
      end
    end
  end

  // Previous filtered levels for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_r <= '0;
    end else begin
      prev_r <= filt_r;
    end
  end

  // ==========================================================================
  // Command pulse decode into up/down counts
  logic cmd_up;
  logic cmd_dn;
  always_comb begin
    cmd_up = 1'b0;
    cmd_dn = 1'b0;
    unique case (form)
      FORM_FWD_REV: begin
        cmd_up = filt_r[0] & ~prev_r[0];
        cmd_dn = filt_r[1] & ~prev_r[1];
      end
      FORM_PULSE_DIR: begin
        cmd_up = filt_r[0] & ~prev_r[0] & ~filt_r[1];
        cmd_dn = filt_r[0] & ~prev_r[0] & filt_r[1];
      end
      FORM_QUAD: begin
        // Four counts per cycle; A leading B is forward
        if (filt_r != prev_r) begin
          cmd_up = filt_r[0] ^ prev_r[1];
          cmd_dn = ~(filt_r[0] ^ prev_r[1]);
        end
      end
      default: ;
    endcase
  end

  // ==========================================================================
  // Deviation counter and in-position flag
  logic signed [31:0] droop_nxt;
  logic        [31:0] droop_abs;
  logic               fb_fwd;
  logic               fb_rev;

  assign fb_fwd = fb_step & fb_ccw;
  assign fb_rev = fb_step & ~fb_ccw;
  // Commands add droop, motor motion consumes it
  always_comb begin
    droop_nxt = droop_r;
    if (cmd_up) droop_nxt = droop_nxt + 32'sd1;
    if (cmd_dn) droop_nxt = droop_nxt - 32'sd1;
    if (fb_fwd) droop_nxt = droop_nxt - 32'sd1;
    if (fb_rev) droop_nxt = droop_nxt + 32'sd1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      droop_r <= '0;
    end else if (dev_clear) begin
      droop_r <= '0;
    end else begin
      droop_r <= droop_nxt;
    end
  end

  assign droop_abs = droop_r[31] ? (~droop_r + 32'd1) : droop_r;
  // Flag looks only at droop, not speed, so slow motion can show in position
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      inpos_r <= 1'b0;
    end else begin
      inpos_r <= (droop_abs <= cfg_r.inpos_range);
    end
  end
  assign in_position = inpos_r;

  // ==========================================================================
  // Encoder position within revolution and zero-point pulse
  logic [REV_W-1:0] rev_pos_r;
  logic [ZW-1:0]    zcnt_r;
  logic             at_zero;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rev_pos_r <= '0;
    end else if (fb_fwd) begin
      rev_pos_r <= (rev_pos_r == REV_W'(CNT_PER_REV - 1)) ? '0 : rev_pos_r + 1'b1;
    end else if (fb_rev) begin
      rev_pos_r <= (rev_pos_r == '0) ? REV_W'(CNT_PER_REV - 1) : rev_pos_r - 1'b1;
    end
  end

  // Reaching position zero from either side marks one revolution
  assign at_zero = (fb_fwd && rev_pos_r == REV_W'(CNT_PER_REV - 1)) ||
                   (fb_rev && rev_pos_r == REV_W'(1));

  // Stretch: retrigger restarts the full width, so no pulse is shorter than the minimum
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      zcnt_r     <= '0;
      z_active_r <= 1'b0;
    end else if (at_zero) begin
      zcnt_r     <= ZW'(ZERO_PULSE_CLKS - 1);
      z_active_r <= 1'b1;
    end else if (zcnt_r != '0) begin
      zcnt_r     <= zcnt_r - 1'b1;
    end else begin
      z_active_r <= 1'b0;
    end
  end

  // ==========================================================================
  // Quadrature output scaling: rate multiplier gives 4*ppr edges per revolution
  logic [REV_W+17:0] acc_r;
  logic [REV_W+17:0] step_k;
  logic [REV_W+17:0] cpr;
  logic [1:0]        quad_r;
  logic              q_up;

  assign step_k = (REV_W + 18)'({cfg_r.ppr, 2'b00});
  assign cpr    = (REV_W + 18)'(CNT_PER_REV);
  assign q_up   = fb_fwd ^ cfg_r.phase_inv;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r  <= '0;
      quad_r <= '0;
    end else if (fb_fwd) begin
      if (acc_r + step_k >= cpr) begin
        acc_r  <= acc_r + step_k - cpr;
        quad_r <= q_up ? quad_r + 1'b1 : quad_r - 1'b1;
      end else begin
        acc_r <= acc_r + step_k;
      end
    end else if (fb_rev) begin
      if (acc_r < step_k) begin
        acc_r  <= acc_r + cpr - step_k;
        quad_r <= q_up ? quad_r + 1'b1 : quad_r - 1'b1;
      end else begin
        acc_r <= acc_r - step_k;
      end
    end
  end

  // ==========================================================================
  // Output drivers; count up gives A then B, so B lags A
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_a_out_p         <= 1'b0;
      enc_a_out_n         <= 1'b1;
      enc_b_out_p         <= 1'b0;
      enc_b_out_n         <= 1'b1;
      enc_z_out_p         <= 1'b0;
      enc_z_out_n         <= 1'b1;
      zero_point_oc_out_n <= 1'b1;
    end else begin
      enc_a_out_p         <= quad_r[0] ^ quad_r[1];
      enc_a_out_n         <= ~(quad_r[0] ^ quad_r[1]);
      enc_b_out_p         <= quad_r[1];
      enc_b_out_n         <= ~quad_r[1];
      enc_z_out_p         <= z_active_r;
      enc_z_out_n         <= ~z_active_r;
      zero_point_oc_out_n <= ~z_active_r;
    end
  end

endmodule : servo_pulse_io

`default_nettype wire

// ===== bench/servo_pulse_io_sva.sv
// Checker: concurrent properties on the servo pulse block's ports
`timescale 1ns/10ps
`default_nettype none
module servo_pulse_io_sva
  import servo_io_pkg::*;
#(parameter int ZERO_PULSE_CLKS = 20) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Motion and outputs
  input wire logic        fb_step,
  input wire logic        enc_a_out_p,
  input wire logic        enc_a_out_n,
  input wire logic        enc_b_out_p,
  input wire logic        enc_b_out_n,
  input wire logic        enc_z_out_p,
  input wire logic        enc_z_out_n,
  input wire logic        zero_point_oc_out_n,
  input wire logic        in_position
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Length of the running zero pulse; a repetition would be far too long to unroll
  logic [31:0] low_cnt_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt_r <= 32'h0;
    else if (!zero_point_oc_out_n) low_cnt_r <= low_cnt_r + 32'h1;
    else low_cnt_r <= 32'h0;
  end

  // ==========================================================================
  // Properties
  a_z_twin: assert property (
    enc_z_out_p != zero_point_oc_out_n && enc_z_out_n == zero_point_oc_out_n) else $error("z outputs disagree");
  a_a_pair: assert property (enc_a_out_n != enc_a_out_p) else $error("a pair not complementary");
  a_b_pair: assert property (enc_b_out_n != enc_b_out_p) else $error("b pair not complementary");
  a_zero_width: assert property (
    $rose(zero_point_oc_out_n) |-> low_cnt_r >= ZERO_PULSE_CLKS) else $error("zero pulse too short");
  a_gray_step: assert property (
    !($changed(enc_a_out_p) && $changed(enc_b_out_p))) else $error("a and b moved together");
  a_zero_cause: assert property (
    $fell(zero_point_oc_out_n) |-> $past(fb_step, 1) || $past(fb_step, 2) || $past(fb_step, 3))
    else $error("zero pulse without motion");
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  a_clear_inpos: assert property (
    (hsel && htrans[1] && hready && hwrite && haddr[7:0] == DEVIATION_OFS) |-> ##[2:4] in_position)
    else $error("cleared droop not in position");
endmodule : servo_pulse_io_sva

bind servo_pulse_io servo_pulse_io_sva #(.ZERO_PULSE_CLKS(ZERO_PULSE_CLKS)) i_servo_pulse_io_sva (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .fb_step(fb_step),
  .enc_a_out_p(enc_a_out_p), .enc_a_out_n(enc_a_out_n), .enc_b_out_p(enc_b_out_p),
  .enc_b_out_n(enc_b_out_n), .enc_z_out_p(enc_z_out_p), .enc_z_out_n(enc_z_out_n),
  .zero_point_oc_out_n(zero_point_oc_out_n), .in_position(in_position));
`default_nettype wire

// ===== bench/host_pulse_gen.sv
// Host controller model: drives command pulse trains in every form
`timescale 1ns/10ps
`default_nettype none
module host_pulse_gen (
  // Clock
  input  wire logic hclk,
  // Command pins
  output var  logic fwd_pin,
  output var  logic rev_pin
);
  logic neg_r = 1'b1; // Pin inversion, negative logic after reset

  initial begin
    fwd_pin = 1'b1;
    rev_pin = 1'b1;
  end

  // One level pair held for w cycles
  task automatic lv(input logic a, input logic b, input int w);
    @(posedge hclk);
    fwd_pin <= a ^ neg_r;
    rev_pin <= b ^ neg_r;
    repeat (w - 1) @(posedge hclk);
  endtask : lv

  // Widths of 100 cycles or more stay within 1 Mpps; shorter ones model line noise
  task automatic send(input logic [1:0] form, input int n, input logic rev, input int w);
    repeat (n) begin
      if (form == 2'h2) begin // Quadrature, A leads for forward
        lv(1'b1, 1'b0, w);
        lv(1'b1, 1'b1, w);
        lv(1'b0, 1'b1, w);
        lv(1'b0, 1'b0, w);
      end else if (form == 2'h1) begin // Sign settles before the pulse
        lv(1'b0, rev, w);
        lv(1'b1, rev, w);
        lv(1'b0, rev, w);
      end else begin
        lv(!rev, rev, w);
        lv(1'b0, 1'b0, w);
      end
    end
  endtask : send
endmodule : host_pulse_gen
`default_nettype wire

// ===== bench/tb.sv
// Testbench: register, command pulse, droop and encoder output checks
`timescale 1ns/10ps
`default_nettype none
module tb;
  import servo_io_pkg::*;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        fwd_pin;
  logic        rev_pin;
  logic        fb_step;
  logic        fb_ccw;
  logic        a_p, a_n, b_p, b_n, z_p, z_n, oc_n, in_position;
  int          err_count;
  int          samples_checked;
  int          zcnt = 0;
  logic        oc_q = 1'b1;

  servo_pulse_io #(.CNT_PER_REV(64), .ZERO_PULSE_CLKS(20)) i_servo_pulse_io (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fwd_cmd_pulse_in(fwd_pin), .rev_cmd_pulse_in(rev_pin), .fb_step(fb_step),
    .fb_ccw(fb_ccw), .enc_a_out_p(a_p), .enc_a_out_n(a_n), .enc_b_out_p(b_p), .enc_b_out_n(b_n),
    .enc_z_out_p(z_p), .enc_z_out_n(z_n), .zero_point_oc_out_n(oc_n), .in_position(in_position));
  host_pulse_gen i_host_pulse_gen (.hclk(hclk), .fwd_pin(fwd_pin), .rev_pin(rev_pin));

  // Clock and zero pulse counter
  always #2.5 hclk = ~hclk;
  always @(posedge hclk) begin
    oc_q <= oc_n;
    if (oc_q && !oc_n) zcnt <= zcnt + 1;
  end

  // ==========================================================================
  // Tasks
  task automatic results();
    if (err_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp

  // Single word transfer from a rising edge; both phases wait for ready, read data taken at the second
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, e);
  endtask : chk

  task automatic step(input logic ccw, input int n);
    @(posedge hclk);
    repeat (n) begin
      fb_step <= 1'b1;
      fb_ccw  <= ccw;
      @(posedge hclk);
      fb_step <= 1'b0;
      @(posedge hclk);
    end
  endtask : step

  // Switch pin logic, settle pins, set the form and clear droop from the switch-over
  task automatic setup(input logic neg, input logic [31:0] form);
    i_host_pulse_gen.neg_r = neg;
    i_host_pulse_gen.lv(1'b0, 1'b0, 4);
    wr(CMD_FORM_OFS, form);
    wr(DEVIATION_OFS, 32'h0);
  endtask : setup

  // Hang guard, a few times the expected run
  initial begin
    repeat (40000) @(posedge hclk);
    err_count++;
    results();
  end

  // ==========================================================================
  // Sequence
  initial begin
    logic [1:0] ab;
    int         z0;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fb_step = 1'b0;
    fb_ccw = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk(CMD_FORM_OFS, {20'h0, CMD_FORM_RST});
    chk(INPOS_RANGE_OFS, INPOS_RANGE_RST);
    chk(PPR_OFS, {16'h0, PPR_RST});
    chk(PHASE_SEL_OFS, 32'h0);
    chk(8'h40, 32'h0);
    chk(STATUS_OFS, 32'h1);
    cmp({31'h0, in_position}, 32'h1);
    wr(PPR_OFS, 32'h10);
    // Default form: three forward, one reverse, then one motor step
    i_host_pulse_gen.send(2'h0, 3, 1'b0, 100);
    i_host_pulse_gen.send(2'h0, 1, 1'b1, 100);
    repeat (6) @(posedge hclk);
    chk(DEVIATION_OFS, 32'h2);
    step(1'b1, 1);
    chk(DEVIATION_OFS, 32'h1);
    cmp({31'h0, in_position}, 32'h1);
    wr(INPOS_RANGE_OFS, 32'h0);
    repeat (4) @(negedge hclk);
    cmp({31'h0, in_position}, 32'h0);
    wr(INPOS_RANGE_OFS, 32'h1);
    repeat (4) @(negedge hclk);
    cmp({31'h0, in_position}, 32'h1);
    // Every form in both logics: reverse trains, then one forward quadrature cycle
    for (int f = 0; f < 3; f++) begin
      for (int l = 0; l < 2; l++) begin
        setup(l[0], 32'(f + 16 * l));
        i_host_pulse_gen.send(f[1:0], (f == 2) ? 1 : 2, 1'b1, 100);
        repeat (6) @(posedge hclk);
        chk(DEVIATION_OFS, (f == 2) ? 32'h4 : 32'hFFFF_FFFE);
      end
    end
    // Filters: a glitch below the filter length is dropped, a long pulse counts
    for (int k = 1; k < 3; k++) begin
      setup(1'b1, 32'(256 * k + 16));
      i_host_pulse_gen.send(2'h0, 1, 1'b0, 50 * k - 40);
      i_host_pulse_gen.send(2'h0, 1, 1'b0, 50 * k + 50);
      repeat (120) @(posedge hclk);
      chk(DEVIATION_OFS, 32'h1);
    end
    // Quadrature order per step, both phase selections
    for (int k = 0; k < 2; k++) begin
      wr(PHASE_SEL_OFS, 32'(k));
      for (int i = 0; i < 4; i++) begin
        ab = {a_p, b_p};
        step(1'b1, 1);
        repeat (3) @(negedge hclk);
        cmp({30'h0, a_p, b_p}, {30'h0, (k == 1) ? {ab[0], ~ab[1]} : {~ab[0], ab[1]}});
      end
    end
    // Half the pulses per revolution: two steps per quadrature state
    wr(PHASE_SEL_OFS, 32'h0);
    wr(PPR_OFS, 32'h8);
    ab = {a_p, b_p};
    step(1'b1, 2);
    repeat (3) @(negedge hclk);
    cmp({30'h0, a_p, b_p}, {30'h0, ~ab[0], ab[1]});
    // One full revolution gives exactly one zero pulse
    z0 = zcnt;
    repeat (64) begin
      step(1'b1, 1);
      repeat (25) @(posedge hclk);
    end
    cmp(32'(zcnt - z0), 32'h1);
    results();
  end
endmodule : tb
`default_nettype wire
